// *** core/hsl_pkg.sv ***
/*
 * Shared constants for the hot-swap status and limits command bank:
 * command codes, field widths, status bit positions, reset values,
 * step timing and the turn-on/turn-off sequencer states.
 * Assumes a single 40 MHz device clock.
 */
package hsl_pkg;

	// Command codes as seen on the management bus
	localparam logic [7:0] CMD_CLEAR_FAULTS = 8'h03;
	localparam logic [7:0] CMD_PG_ON        = 8'h5E;
	localparam logic [7:0] CMD_PG_OFF       = 8'h5F;
	localparam logic [7:0] CMD_STARTUP_LAG  = 8'h60;
	localparam logic [7:0] CMD_SHUTDOWN_LAG = 8'h64;
	localparam logic [7:0] CMD_PWR_WARN     = 8'h6A;
	localparam logic [7:0] CMD_STATUS_BYTE  = 8'h78;
	localparam logic [7:0] CMD_STATUS_WORD  = 8'h79;

	// Field widths, all fields sit at bit 0
	localparam int DATA_W = 16;
	localparam int PG_W   = 10;
	localparam int LAG_W  = 8;
	localparam int PWR_W  = 14;
	localparam int STAT_W = 8;
	localparam int FLAG_W = 5;

	// Summary status bit positions
	localparam int ST_BUSY = 7;
	localparam int ST_OFF  = 6;
	localparam int ST_OC   = 4;
	localparam int ST_UV   = 3;
	localparam int ST_TEMP = 2;
	localparam int ST_COMM = 1;
	localparam int ST_SS   = 0;

	// Reset values of the writable fields
	localparam logic [PG_W-1:0]  PG_ON_RST    = 10'h000;
	localparam logic [PG_W-1:0]  PG_OFF_RST   = 10'h000;
	localparam logic [LAG_W-1:0] LAG_RST      = 8'h00;
	localparam logic [PWR_W-1:0] PWR_WARN_RST = 14'h3FFF;

	// Lag step timing
	localparam int CLK_PERIOD_NS = 25;
	localparam int STEP_TIME_NS  = 100000;
	localparam int TICK_CYCLES   = (STEP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int TICK_W        = 12;

	typedef enum logic [1:0] {
		SEQ_OFF,
		SEQ_ON_WAIT,
		SEQ_ON,
		SEQ_OFF_WAIT
	} hsl_seq_t;

endpackage

// *** core/hsl_status_limits.sv ***
/*
 * Hot-swap command bank: power-good thresholds, startup and shutdown
 * lags driving the output ramp request, input power warning limit and
 * the summary status byte with latched fault flags.
 * Assumes command decode of the management bus happens upstream and
 * arrives as one-cycle write and read strobes; fault events come from
 * logic on the same clock, the enable comes straight from a pin.
 */
`timescale 1ns/1ps

// Functional notes
// - Power-good falling threshold: 10-bit field, 62.5 mV steps, drops power-good.
// - Reserved bits ignore writes and always read back as zero.
// - Enable rise waits startup lag (0.1 ms steps) before raising ramp.
// - Enable fall waits shutdown lag (0.1 ms steps) before dropping ramp.
// - Input power warning limit: 14-bit field, 4 W steps, warning threshold.
// - Status bit 7 shows memory busy; writes are ignored meanwhile.
// - Status bit 6 reads one whenever the output is off.
// - Status bit 4 latches over-current trip until clear-faults command.
// - Status bit 3 latches input under-voltage until clear-faults.
// - Status bit 2 latches over-temperature fault or warning until clear-faults.
// - Status bit 1 latches any communication fault until clear-faults.
// - Status bit 0 set when soft-start below 340 mV at timeout.
// - Status byte is read-only; fault bits zero when nothing occurred.
// - Status word low byte mirrors the status byte.
// - Power-good rising threshold, same scaling, asserts power-good when reached.
module hsl_status_limits #(
	parameter int TICK_CYCLES = hsl_pkg::TICK_CYCLES
) (
	input  wire logic                       clock_i,
	input  wire logic                       rst_b_i,
	input  wire logic [7:0]                 cmd_i,
	input  wire logic                       wr_i,
	input  wire logic [hsl_pkg::DATA_W-1:0] wdata_i,
	input  wire logic                       rd_i,
	input  wire logic                       en_pin_i,
	input  wire logic                       config_memory_busy_flag_i,
	input  wire logic                       prot_off_i,
	input  wire logic                       cmd_off_i,
	input  wire logic                       oc_trip_i,
	input  wire logic                       uv_fault_i,
	input  wire logic                       temp_event_i,
	input  wire logic                       comm_fault_i,
	input  wire logic                       ss_timer_done_i,
	input  wire logic                       ss_below_i,
	input  wire logic [hsl_pkg::PG_W-1:0]   vmon_i,
	input  wire logic [hsl_pkg::PWR_W-1:0]  pin_pwr_i,
	output logic [hsl_pkg::DATA_W-1:0]      rdata_o,
	output logic                            rvalid_o,
	output logic                            ramp_on_o,
	output logic                            power_good_indicator_o,
	output logic                            power_warn_o
);

	// Elaboration check: the tick counter is only TICK_W bits wide
	if (TICK_CYCLES < 1 || TICK_CYCLES > (1 << hsl_pkg::TICK_W))
	begin : g_tick_range
		$error("TICK_CYCLES out of range for the tick counter");
	end

	// Known command codes, used by the bad-write decode only
	function automatic logic cmd_known(input logic [7:0] c);
		cmd_known = (c == hsl_pkg::CMD_PG_ON) || (c == hsl_pkg::CMD_PG_OFF)
			|| (c == hsl_pkg::CMD_STARTUP_LAG) || (c == hsl_pkg::CMD_SHUTDOWN_LAG)
			|| (c == hsl_pkg::CMD_PWR_WARN) || (c == hsl_pkg::CMD_STATUS_BYTE)
			|| (c == hsl_pkg::CMD_STATUS_WORD);
	endfunction

	logic [hsl_pkg::PG_W-1:0]   pg_on_reg;
	logic [hsl_pkg::PG_W-1:0]   pg_off_reg;
	logic [hsl_pkg::LAG_W-1:0]  startup_lag_reg;
	logic [hsl_pkg::LAG_W-1:0]  shutdown_lag_reg;
	logic [hsl_pkg::PWR_W-1:0]  pwr_warn_reg;
	logic [hsl_pkg::FLAG_W-1:0] flag_reg;
	logic                       en_s1_reg;
	logic                       en_s2_reg;
	logic                       en_s3_reg;
	logic                       en_reg;
	hsl_pkg::hsl_seq_t          seq_reg;
	hsl_pkg::hsl_seq_t          seq_next;
	logic [hsl_pkg::TICK_W-1:0] tick_reg;
	logic [hsl_pkg::LAG_W-1:0]  step_reg;
	logic [hsl_pkg::STAT_W-1:0] status_next;
	logic [hsl_pkg::FLAG_W-1:0] event_vec;
	logic                       wr_ok;
	logic                       clear_req;
	logic                       bad_write;
	logic                       force_off;
	logic                       tick;
	logic                       startup_done;
	logic                       shutdown_done;

	// Writes while the memory is busy are dropped without a trace
	assign wr_ok     = wr_i && !config_memory_busy_flag_i;
	assign clear_req = wr_ok && (cmd_i == hsl_pkg::CMD_CLEAR_FAULTS);
	// Writing a read-only or unknown code counts as a comm fault
	assign bad_write = wr_ok && !clear_req && (!cmd_known(cmd_i)
		|| cmd_i == hsl_pkg::CMD_STATUS_BYTE || cmd_i == hsl_pkg::CMD_STATUS_WORD);
	assign force_off = prot_off_i || cmd_off_i;

	// Writable fields; upper bits of the write word are simply not stored
	always_ff @(posedge clock_i)
	begin
		if (!rst_b_i)
		begin
			pg_on_reg        <= hsl_pkg::PG_ON_RST;
			pg_off_reg       <= hsl_pkg::PG_OFF_RST;
			startup_lag_reg  <= hsl_pkg::LAG_RST;
			shutdown_lag_reg <= hsl_pkg::LAG_RST;
			pwr_warn_reg     <= hsl_pkg::PWR_WARN_RST;
		end
		else if (wr_ok)
		begin
			case (cmd_i)
				hsl_pkg::CMD_PG_ON:        pg_on_reg <= wdata_i[hsl_pkg::PG_W-1:0];
				hsl_pkg::CMD_PG_OFF:       pg_off_reg <= wdata_i[hsl_pkg::PG_W-1:0];
				hsl_pkg::CMD_STARTUP_LAG:  startup_lag_reg <= wdata_i[hsl_pkg::LAG_W-1:0];
				hsl_pkg::CMD_SHUTDOWN_LAG: shutdown_lag_reg <= wdata_i[hsl_pkg::LAG_W-1:0];
				hsl_pkg::CMD_PWR_WARN:     pwr_warn_reg <= wdata_i[hsl_pkg::PWR_W-1:0];
				default:                   pg_on_reg <= pg_on_reg;
			endcase
		end
	end

	// Enable pin synchroniser; a change counts once stages two and three agree
	always_ff @(posedge clock_i)
	begin
		if (!rst_b_i)
		begin
			en_s1_reg <= 1'b0;
			en_s2_reg <= 1'b0;
			en_s3_reg <= 1'b0;
			en_reg    <= 1'b0;
		end
		else
		begin
			en_s1_reg <= en_pin_i;
			en_s2_reg <= en_s1_reg;
			en_s3_reg <= en_s2_reg;
			if (en_s2_reg == en_s3_reg)
				en_reg <= en_s3_reg;
		end
	end

	// Step timer from the device clock, restarted on every state change
	assign tick          = (tick_reg == hsl_pkg::TICK_W'(TICK_CYCLES - 1));
	assign startup_done  = (step_reg == startup_lag_reg);
	assign shutdown_done = (step_reg == shutdown_lag_reg);

	always_ff @(posedge clock_i)
	begin
		if (!rst_b_i || seq_next != seq_reg)
		begin
			tick_reg <= '0;
			step_reg <= '0;
		end
		else if (tick)
		begin
			tick_reg <= '0;
			step_reg <= step_reg + hsl_pkg::LAG_W'(1);
		end
		else
			tick_reg <= tick_reg + hsl_pkg::TICK_W'(1);
	end

	// Turn-on/turn-off sequencer; zero lag skips the wait state entirely
	always_comb
	begin
		seq_next = seq_reg;
		case (seq_reg)
			hsl_pkg::SEQ_OFF:
				if (en_reg && !force_off)
					seq_next = (startup_lag_reg == '0) ? hsl_pkg::SEQ_ON
						: hsl_pkg::SEQ_ON_WAIT;
			hsl_pkg::SEQ_ON_WAIT:
				if (!en_reg || force_off)
					seq_next = hsl_pkg::SEQ_OFF;
				else if (startup_done)
					seq_next = hsl_pkg::SEQ_ON;
			hsl_pkg::SEQ_ON:
				if (force_off)
					seq_next = hsl_pkg::SEQ_OFF;
				else if (!en_reg)
					seq_next = (shutdown_lag_reg == '0) ? hsl_pkg::SEQ_OFF
						: hsl_pkg::SEQ_OFF_WAIT;
			hsl_pkg::SEQ_OFF_WAIT:
				if (force_off || shutdown_done)
					seq_next = hsl_pkg::SEQ_OFF;
				else if (en_reg)
					seq_next = hsl_pkg::SEQ_ON;
			default:
				seq_next = hsl_pkg::SEQ_OFF;
		endcase
	end

	always_ff @(posedge clock_i)
	begin
		if (!rst_b_i)
			seq_reg <= hsl_pkg::SEQ_OFF;
		else
			seq_reg <= seq_next;
	end

	// Ramp request held through the shutdown wait, so it drops at its end unless forced off earlier
	always_ff @(posedge clock_i)
	begin
		if (!rst_b_i)
			ramp_on_o <= 1'b0;
		else
			ramp_on_o <= (seq_next == hsl_pkg::SEQ_ON) || (seq_next == hsl_pkg::SEQ_OFF_WAIT);
	end

	// Power-good hysteresis and input power warning comparators
	always_ff @(posedge clock_i)
	begin
		if (!rst_b_i)
			power_good_indicator_o <= 1'b0;
		else if (vmon_i >= pg_on_reg)
			power_good_indicator_o <= 1'b1;
		else if (vmon_i <= pg_off_reg)
			power_good_indicator_o <= 1'b0;
	end

	always_ff @(posedge clock_i)
	begin
		if (!rst_b_i)
			power_warn_o <= 1'b0;
		else
			power_warn_o <= (pin_pwr_i > pwr_warn_reg);
	end

	// Latched fault flags; a new event beats a clear in the same cycle
	assign event_vec[hsl_pkg::ST_OC]   = oc_trip_i;
	assign event_vec[hsl_pkg::ST_UV]   = uv_fault_i;
	assign event_vec[hsl_pkg::ST_TEMP] = temp_event_i;
	assign event_vec[hsl_pkg::ST_COMM] = comm_fault_i || bad_write;
	assign event_vec[hsl_pkg::ST_SS]   = ss_timer_done_i && ss_below_i;

	always_ff @(posedge clock_i)
	begin
		if (!rst_b_i)
			flag_reg <= '0;
		else
			flag_reg <= event_vec | (flag_reg & ~{hsl_pkg::FLAG_W{clear_req}});
	end

	// Status byte: live busy and off bits, bit 5 reserved
	always_comb
	begin
		status_next                   = '0;
		status_next[hsl_pkg::FLAG_W-1:0] = flag_reg;
		status_next[hsl_pkg::ST_BUSY] = config_memory_busy_flag_i;
		status_next[hsl_pkg::ST_OFF]  = !ramp_on_o;
	end

	// Read port: one-cycle answer, reserved bits padded with zeros
	always_ff @(posedge clock_i)
	begin
		if (!rst_b_i)
		begin
			rdata_o  <= '0;
			rvalid_o <= 1'b0;
		end
		else
		begin
			rvalid_o <= rd_i;
			if (rd_i)
			begin
				case (cmd_i)
					hsl_pkg::CMD_PG_ON:        rdata_o <= {6'h00, pg_on_reg};
					hsl_pkg::CMD_PG_OFF:       rdata_o <= {6'h00, pg_off_reg};
					hsl_pkg::CMD_STARTUP_LAG:  rdata_o <= {8'h00, startup_lag_reg};
					hsl_pkg::CMD_SHUTDOWN_LAG: rdata_o <= {8'h00, shutdown_lag_reg};
					hsl_pkg::CMD_PWR_WARN:     rdata_o <= {2'h0, pwr_warn_reg};
					hsl_pkg::CMD_STATUS_BYTE:  rdata_o <= {8'h00, status_next};
					hsl_pkg::CMD_STATUS_WORD:  rdata_o <= {8'h00, status_next};
					default:                   rdata_o <= '0;
				endcase
			end
		end
	end

	default clocking cb @(posedge clock_i); endclocking
	default disable iff (!rst_b_i);

	a_reserved_read_zero: assert property (rd_i && cmd_i == hsl_pkg::CMD_PG_OFF
		|=> rdata_o[15:10] == 6'h00) else $error("reserved bits read nonzero");
	a_busy_blocks_write: assert property (wr_i && config_memory_busy_flag_i
		|=> $stable(pg_off_reg) && $stable(startup_lag_reg)) else $error("write taken while busy");
	a_off_bit_tracks: assert property (rd_i && cmd_i == hsl_pkg::CMD_STATUS_BYTE
		|=> rdata_o[hsl_pkg::ST_OFF] == !$past(ramp_on_o)) else $error("off bit wrong");
	a_oc_latch_holds: assert property (oc_trip_i
		|| (flag_reg[hsl_pkg::ST_OC] && !clear_req) |=> flag_reg[hsl_pkg::ST_OC])
		else $error("oc flag lost");
	a_clear_wins_late: assert property (clear_req && !uv_fault_i
		|=> !flag_reg[hsl_pkg::ST_UV]) else $error("uv flag not cleared");
	a_set_beats_clear: assert property (clear_req && temp_event_i
		|=> flag_reg[hsl_pkg::ST_TEMP]) else $error("event lost to clear");
	a_bad_write_comm: assert property (bad_write
		|=> flag_reg[hsl_pkg::ST_COMM]) else $error("comm flag not set");
	a_ss_timeout_flag: assert property (ss_timer_done_i && ss_below_i
		|=> flag_reg[hsl_pkg::ST_SS]) else $error("soft-start fault missed");
	a_word_mirrors_byte: assert property (rd_i && cmd_i == hsl_pkg::CMD_STATUS_WORD
		|=> rdata_o[15:8] == 8'h00 && rdata_o[4:0] == $past(flag_reg)) else $error("word mismatch");
	a_zero_lag_direct: assert property (seq_reg == hsl_pkg::SEQ_OFF
		&& en_reg && !force_off && startup_lag_reg == '0 |=> ramp_on_o)
		else $error("zero lag delayed ramp");
	a_no_early_ramp: assert property (seq_reg == hsl_pkg::SEQ_ON_WAIT
		&& step_reg < startup_lag_reg |=> seq_reg != hsl_pkg::SEQ_ON) else $error("ramp too early");
	a_off_lag_holds: assert property (seq_reg == hsl_pkg::SEQ_OFF_WAIT && !force_off
		&& step_reg < shutdown_lag_reg |-> ##1 ramp_on_o) else $error("ramp dropped early");
	a_pg_falls: assert property (vmon_i <= pg_off_reg && vmon_i < pg_on_reg
		|=> !power_good_indicator_o) else $error("power good not dropped");
	a_pg_rises: assert property (vmon_i >= pg_on_reg
		|=> power_good_indicator_o) else $error("power good not raised");
	a_warn_limit: assert property (pin_pwr_i > pwr_warn_reg
		|=> power_warn_o) else $error("power warning missed");

endmodule

// *** verification/hsl_host_model.sv ***
/*
 * Host-side model of the command port: one-cycle write and read strobes.
 * Assumes the device samples strobes on the rising clock edge.
 */
`timescale 1ns/1ps
module hsl_host_model (
	input  wire logic        clock_i,
	input  wire logic        config_memory_busy_flag_i,
	output logic [7:0]       cmd_o,
	output logic             wr_o,
	output logic [15:0]      wdata_o,
	output logic             rd_o
);
	// Quiet bus at time zero
	initial
	begin
		cmd_o = 8'h00;
		wr_o = 1'b0;
		wdata_o = 16'h0000;
		rd_o = 1'b0;
	end

	// One transfer, launched and released on falling edges
	task automatic xfer(input logic w, input logic [7:0] c, input logic [15:0] d,
		input logic poll);
		int n;
		n = 0;
		@(negedge clock_i);
		while (poll && config_memory_busy_flag_i && n < 100)
		begin
			@(negedge clock_i);
			n++;
		end
		cmd_o = c;
		wdata_o = d;
		wr_o = w;
		rd_o = !w;
		@(negedge clock_i);
		wr_o = 1'b0;
		rd_o = 1'b0;
		// Idle lines show inverted junk so no stale value passes
		cmd_o = ~c;
		wdata_o = ~d;
	endtask
endmodule

// *** verification/tb_hsl_status_limits.sv ***
/*
 * Self-checking bench for the status and limits command bank.
 * Assumes the host model drives the command port; TICK_CYCLES shortened to 4.
 */
`timescale 1ns/1ps
module tb_hsl_status_limits;
	localparam int TK = 4;
	logic        clock_i, rst_b_i, en, busy, prot, coff, ss_below;
	logic [4:0]  ev;
	logic [9:0]  vmon;
	logic [13:0] pwr;
	logic [7:0]  cmd;
	logic        wr, rd, rvalid_o, ramp_on_o, pg_o, warn_o;
	logic [15:0] wdata, rdata_o, d;
	logic [15:0] exp_q[$];
	int          mismatches, compares;
	logic [7:0]  cmds[4] = '{8'h5F, 8'h60, 8'h64, 8'h6A};
	logic [15:0] msk[4] = '{16'h03FF, 16'h00FF, 16'h00FF, 16'h3FFF};

	hsl_status_limits #(.TICK_CYCLES(TK)) u_hsl_status_limits (.clock_i(clock_i),
		.rst_b_i(rst_b_i), .cmd_i(cmd), .wr_i(wr), .wdata_i(wdata), .rd_i(rd),
		.en_pin_i(en), .config_memory_busy_flag_i(busy), .prot_off_i(prot), .cmd_off_i(coff),
		.oc_trip_i(ev[4]), .uv_fault_i(ev[3]), .temp_event_i(ev[2]),
		.comm_fault_i(ev[1]), .ss_timer_done_i(ev[0]), .ss_below_i(ss_below),
		.vmon_i(vmon), .pin_pwr_i(pwr), .rdata_o(rdata_o), .rvalid_o(rvalid_o),
		.ramp_on_o(ramp_on_o), .power_good_indicator_o(pg_o), .power_warn_o(warn_o));
	hsl_host_model u_hsl_host_model (.clock_i(clock_i), .config_memory_busy_flag_i(busy), .cmd_o(cmd),
		.wr_o(wr), .wdata_o(wdata), .rd_o(rd));

	// 40 MHz clock
	always #12.5 clock_i = ~clock_i;

	task automatic check(input logic [15:0] g, input logic [15:0] e);
		compares++;
		if (g !== e)
		begin
			mismatches++;
			$display("CHECK FAILED at %0t got %h exp %h", $time, g, e);
		end
	endtask
	task automatic check_bit(input logic g, input logic e);
		check({15'h0000, g}, {15'h0000, e});
	endtask
	task automatic wrc(input logic [7:0] c, input logic [15:0] v);
		u_hsl_host_model.xfer(1'b1, c, v, 1'b1);
	endtask
	// Note the expected word, then strobe the read
	task automatic rdc(input logic [7:0] c, input logic [15:0] e);
		exp_q.push_back(e);
		u_hsl_host_model.xfer(1'b0, c, 16'h0000, 1'b0);
	endtask
	task automatic settle(input int n);
		repeat (n) @(negedge clock_i);
	endtask
	// Bounded wait on the ramp request, then compare
	task automatic wait_ramp(input logic e, input int lim);
		int n;
		n = 0;
		while (ramp_on_o !== e && n < lim)
		begin
			@(negedge clock_i);
			n++;
		end
		check_bit(ramp_on_o, e);
	endtask
	task automatic close_out;
		// A read that never answered leaves its note behind
		if (exp_q.size() != 0)
			mismatches++;
		$display("mismatches %0d compares %0d", mismatches, compares);
		if (mismatches == 0 && compares > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	// Read monitor: an unexpected answer meets an unknown and fails
	always @(negedge clock_i)
		if (rvalid_o === 1'b1)
			check(rdata_o, exp_q.size() > 0 ? exp_q.pop_front() : 16'hXXXX);

	// Watchdog, far beyond the expected few hundred cycles
	initial
	begin
		#(25 * 5000);
		mismatches++;
		close_out();
	end

	initial
	begin
		clock_i = 1'b0;
		{rst_b_i, en, busy, prot, coff, ev} = '0;
		ss_below = 1'b1;
		vmon = 10'h000;
		pwr = 14'h0000;
		mismatches = 0;
		compares = 0;
		d = 16'($urandom(32'hCDC4));
		repeat (4) @(posedge clock_i);
		@(negedge clock_i);
		rst_b_i = 1'b1;
		rdc(8'h5F, 16'h0000);
		rdc(8'h60, 16'h0000);
		rdc(8'h64, 16'h0000);
		rdc(8'h6A, 16'h3FFF);
		rdc(8'h78, 16'h0040);
		// All ones, then random words; reserved bits must read zero
		for (int j = 0; j < 3; j++)
			for (int i = 0; i < 4; i++)
			begin
				d = (j == 0) ? 16'hFFFF : 16'($urandom());
				wrc(cmds[i], d);
				rdc(cmds[i], d & msk[i]);
			end
		// Writes while memory busy are dropped
		wrc(8'h60, 16'h0011);
		busy = 1'b1;
		u_hsl_host_model.xfer(1'b1, 8'h60, 16'h00AA, 1'b0);
		rdc(8'h78, 16'h00C0);
		busy = 1'b0;
		rdc(8'h60, 16'h0011);
		// Each latched flag, mirrored in the word, cleared by 03h
		for (int k = 0; k < 5; k++)
		begin
			ev[k] = 1'b1;
			settle(1);
			ev = 5'h00;
			settle(3);
			rdc(8'h78, 16'h0040 | (16'h0001 << k));
			rdc(8'h79, 16'h0040 | (16'h0001 << k));
			wrc(8'h03, 16'h0000);
			rdc(8'h78, 16'h0040);
		end
		// Clear and a fresh event in one cycle: the event wins
		ev[2] = 1'b1;
		wrc(8'h03, 16'h0000);
		ev = 5'h00;
		rdc(8'h78, 16'h0044);
		wrc(8'h03, 16'h0000);
		ss_below = 1'b0;
		ev[0] = 1'b1;
		settle(1);
		ev = 5'h00;
		rdc(8'h78, 16'h0040);
		wrc(8'h78, 16'h00FF);
		rdc(8'h78, 16'h0042);
		wrc(8'h03, 16'h0000);
		// Startup and shutdown lags; the pin needs four edges to reach the sequencer
		wrc(8'h60, 16'h0003);
		wrc(8'h64, 16'h0002);
		en = 1'b1;
		repeat (3 * TK + 4) @(negedge clock_i) check_bit(ramp_on_o, 1'b0);
		wait_ramp(1'b1, 3);
		rdc(8'h78, 16'h0000);
		en = 1'b0;
		repeat (2 * TK + 5) @(negedge clock_i) check_bit(ramp_on_o, 1'b1);
		wait_ramp(1'b0, 3);
		rdc(8'h78, 16'h0040);
		// Zero lags: the ramp follows the synchronised pin with no added wait
		wrc(8'h60, 16'h0000);
		wrc(8'h64, 16'h0000);
		en = 1'b1;
		wait_ramp(1'b1, 5);
		en = 1'b0;
		wait_ramp(1'b0, 5);
		// Command and protection each force the output off at the next edge
		en = 1'b1;
		wait_ramp(1'b1, 5);
		coff = 1'b1;
		settle(1);
		check_bit(ramp_on_o, 1'b0);
		rdc(8'h78, 16'h0040);
		en = 1'b0;
		settle(6);
		coff = 1'b0;
		en = 1'b1;
		wait_ramp(1'b1, 5);
		prot = 1'b1;
		settle(1);
		check_bit(ramp_on_o, 1'b0);
		rdc(8'h78, 16'h0040);
		en = 1'b0;
		settle(6);
		prot = 1'b0;
		// Power-good hysteresis between rising and falling thresholds
		wrc(8'h5E, 16'h0064);
		wrc(8'h5F, 16'h0050);
		settle(2);
		check_bit(pg_o, 1'b0);
		vmon = 10'h063;
		settle(3);
		check_bit(pg_o, 1'b0);
		vmon = 10'h064;
		settle(3);
		check_bit(pg_o, 1'b1);
		vmon = 10'h05A;
		settle(3);
		check_bit(pg_o, 1'b1);
		vmon = 10'h050;
		settle(3);
		check_bit(pg_o, 1'b0);
		// Warning only above the limit
		wrc(8'h6A, 16'h0032);
		pwr = 14'h0032;
		settle(3);
		check_bit(warn_o, 1'b0);
		pwr = 14'h0033;
		settle(3);
		check_bit(warn_o, 1'b1);
		// Mid-run reset returns the written fields to their reset values
		rst_b_i = 1'b0;
		settle(4);
		rst_b_i = 1'b1;
		rdc(8'h5E, 16'h0000);
		rdc(8'h6A, 16'h3FFF);
		check_bit(warn_o, 1'b0);
		settle(5);
		close_out();
	end
endmodule
